// File: verilog/adcf_cfg.svh
`ifndef ADCF_CFG_SVH
`define ADCF_CFG_SVH

// ----------------------------------------------------------------
// word and pipeline geometry
// ----------------------------------------------------------------
`define ADCF_DATA_W      14
`define ADCF_MSB         13
`define ADCF_LATENCY     10
`define ADCF_MEM_DEPTH   9
`define ADCF_PTR_W       4
`define ADCF_CNT_W       4

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADCF_OFF_CTRL    8'h00
`define ADCF_OFF_STATUS  8'h04
`define ADCF_OFF_MASK    8'h08
`define ADCF_OFF_LAST    8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADCF_CTRL_TWOS   0
`define ADCF_CTRL_OEDIS  1
`define ADCF_CTRL_PD     2
`define ADCF_EVT_OVR     0
`define ADCF_EVT_RESUME  1
`define ADCF_LAST_OVR    14
`define ADCF_LAST_VALID  15

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ADCF_CTRL_RST    3'h0
`define ADCF_EVT_RST     2'h0

`endif

// File: verilog/adcf_pkg.sv
package adcf_pkg;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [13:0] adcf_word_t;
    typedef logic [2:0]  adcf_ctrl_t;
    typedef logic [1:0]  adcf_evt_t;

    // msb inversion turns offset binary into twos complement
    function automatic adcf_word_t adcf_to_twos(input adcf_word_t ob);
        adcf_to_twos = {~ob[13], ob[12:0]};
    endfunction

endpackage

// File: verilog/adcf_delay_mem.sv
`timescale 1ns/1ps
`include "adcf_cfg.svh"

// circular store, read word leaves a register one lap later
module adcf_delay_mem
    import adcf_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data
);

    logic [15:0]             mem [0:`ADCF_MEM_DEPTH-1];
    logic [`ADCF_PTR_W-1:0]  ptr;
    wire                     ptr_wrap = (ptr == `ADCF_PTR_W'(`ADCF_MEM_DEPTH - 1));
    wire [`ADCF_PTR_W-1:0]   next_ptr = ptr_wrap ? '0 : ptr + `ADCF_PTR_W'(1);

    // ----------------------------------------------------------------
    // pointer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr <= '0;
        end else begin
            ptr <= next_ptr;
        end
    end

    // write new word, read the oldest at the same slot
    always_ff @(posedge pclk) begin
        mem[ptr] <= wr_data;
        rd_data  <= mem[ptr];
    end

endmodule

// File: verilog/adcf_coder.sv
`timescale 1ns/1ps
`include "adcf_cfg.svh"

// output coding stage and output register
module adcf_coder
    import adcf_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire adcf_word_t raw_word,
    input  wire logic       raw_over,
    input  wire logic       raw_valid,
    input  wire logic       twos_complement_select,
    output adcf_word_t      data_out,
    output logic            over_range_flag,
    output logic            data_valid
);

    // ----------------------------------------------------------------
    // coding selection
    // ----------------------------------------------------------------
    wire adcf_word_t offset_binary_code = raw_word;                  // RQ3
    wire adcf_word_t twos_word          = adcf_to_twos(raw_word);    // RQ2 RQ12
    wire adcf_word_t next_word          = !raw_valid ? '0 :
                                          twos_complement_select ? twos_word : offset_binary_code; // RQ1
    wire             next_over          = raw_valid & raw_over;      // RQ10

    // output register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out        <= '0;
            over_range_flag <= 1'b0;
            data_valid      <= 1'b0;
        end else begin
            data_out        <= next_word;       // RQ9
            over_range_flag <= next_over;       // RQ9
            data_valid      <= raw_valid;
        end
    end

endmodule

// File: verilog/adcf_top.sv
`timescale 1ns/1ps
`include "adcf_cfg.svh"

// ----------------------------------------------------------------
// converter output port with apb control
// ----------------------------------------------------------------

// Contract
// RQ1: select high gives twos complement, else offset
// RQ2: twos complement is offset word, msb inverted
// RQ3: offset binary: ones top, zeros bottom
// RQ4: enable low drives outputs, high floats them
// RQ5: do not toggle output enable dynamically
// RQ6: sampling clock stays at or above 1MHz
// RQ7: fast sampling needs 50% clock duty
// RQ8: every clock captures and advances one sample
// RQ9: word and flag appear ten cycles later
// RQ10: over-range flag high beyond full scale
// RQ11: power-down discards pipeline, full latency after
// RQ12: fourteen bit word, bit 13 msb
module adcf_top
    import adcf_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire adcf_word_t  core_code,
    input  wire logic        core_over,
    output adcf_word_t       data_out,
    output logic             over_range_flag,
    output logic             data_valid,
    output logic             data_oe_n,
    output logic             irq
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    adcf_ctrl_t             ctrl;
    adcf_evt_t              status;
    adcf_evt_t              mask;
    logic [`ADCF_CNT_W-1:0] run_cnt;
    logic                   valid_q;
    logic [15:0]            mem_rd;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable;
    wire sel_ctrl  = (paddr == `ADCF_OFF_CTRL);
    wire sel_stat  = (paddr == `ADCF_OFF_STATUS);
    wire sel_mask  = (paddr == `ADCF_OFF_MASK);
    wire sel_last  = (paddr == `ADCF_OFF_LAST);
    wire sel_any   = sel_ctrl | sel_stat | sel_mask | sel_last;
    wire wr_ctrl   = access_ph & pwrite & sel_ctrl;
    wire wr_stat   = access_ph & pwrite & sel_stat;
    wire wr_mask   = access_ph & pwrite & sel_mask;

    // control fields
    wire twos_complement_select = ctrl[`ADCF_CTRL_TWOS];
    wire output_disable         = ctrl[`ADCF_CTRL_OEDIS];
    wire power_down_in          = ctrl[`ADCF_CTRL_PD];

    // read mux, sampled in the setup cycle
    wire [31:0] last_word = {16'h0000, data_valid, over_range_flag, data_out};
    wire [31:0] next_rdata = sel_ctrl ? {29'h0, ctrl} :
                             sel_stat ? {30'h0, status} :
                             sel_mask ? {30'h0, mask} :
                             sel_last ? last_word :
                             32'h0000_0000;

    // one wait-free access phase, answer ready at once
    assign pready = penable;

    // ----------------------------------------------------------------
    // bus answer registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= ~sel_any;
        end
    end

    // ----------------------------------------------------------------
    // control and mask registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `ADCF_CTRL_RST;
            mask <= `ADCF_EVT_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= pwdata[2:0];
            end
            if (wr_mask) begin
                mask <= pwdata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // pipeline run counter
    // ----------------------------------------------------------------
    wire run_full   = (run_cnt >= `ADCF_CNT_W'(`ADCF_LATENCY));
    wire [`ADCF_CNT_W-1:0] next_run_cnt = power_down_in ? '0 :         // RQ11
                                          run_full ? run_cnt :
                                          run_cnt + `ADCF_CNT_W'(1);   // RQ8
    // sample leaving the store is trusted only after a clean lap
    wire raw_valid  = ~power_down_in & run_full;                      // RQ11

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt <= '0;
        end else begin
            run_cnt <= next_run_cnt;
        end
    end

    // ----------------------------------------------------------------
    // conversion pipeline: capture each edge, nine stored stages
    // ----------------------------------------------------------------
    adcf_delay_mem u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_data ({1'b0, core_over, core_code}),                      // RQ8
        .rd_data (mem_rd)
    );

    // coding stage adds the tenth cycle
    adcf_coder u_coder (
        .pclk                   (pclk),
        .presetn                (presetn),
        .raw_word               (mem_rd[13:0]),
        .raw_over               (mem_rd[14]),
        .raw_valid              (raw_valid),
        .twos_complement_select (twos_complement_select),
        .data_out               (data_out),
        .over_range_flag        (over_range_flag),
        .data_valid             (data_valid)
    );

    // output drivers, enable low while driving
    assign data_oe_n = output_disable;                                // RQ4

    // ----------------------------------------------------------------
    // events, sticky status, interrupt
    // ----------------------------------------------------------------
    wire       ovr_evt     = data_valid & over_range_flag;
    wire       resume_evt  = data_valid & ~valid_q;
    wire [1:0] evt_set     = {resume_evt, ovr_evt};
    wire [1:0] evt_clr     = wr_stat ? pwdata[1:0] : 2'b00;
    // set beats clear in the same cycle
    wire [1:0] next_status = (status & ~evt_clr) | evt_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status  <= `ADCF_EVT_RST;
            valid_q <= 1'b0;
        end else begin
            status  <= next_status;
            valid_q <= data_valid;
        end
    end

    assign irq = |(status & mask);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    ob_format_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        data_valid && !$past(twos_complement_select) |-> data_out == $past(core_code, 11))
        else $error("offset binary word differs from captured sample");

    tc_format_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        data_valid && $past(twos_complement_select)
        |-> data_out[12:0] == $past(core_code[12:0], 11))
        else $error("twos complement low bits differ from sample");

    tc_msb_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        data_valid && $past(twos_complement_select)
        |-> data_out[13] != $past(core_code[13], 11))
        else $error("twos complement msb not inverted");

    over_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        data_valid |-> over_range_flag == $past(core_over, 11))
        else $error("over-range flag not aligned with its word");

    oe_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        wr_ctrl |=> data_oe_n == $past(pwdata[`ADCF_CTRL_OEDIS]))
        else $error("output enable does not follow control write");

    pd_flush_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        $fell(power_down_in) |-> !data_valid [*8] ##1 !data_valid ##1 !data_valid)
        else $error("data valid before full latency after power-down");

    pipe_run_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        (presetn && !power_down_in) [*8] ##1 (presetn && !power_down_in) [*3] |=> data_valid)
        else $error("no valid word after eleven clean cycles");

    pd_kill_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        power_down_in |=> !data_valid && !over_range_flag)
        else $error("output valid during power-down");

    ovr_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        ovr_evt && mask[`ADCF_EVT_OVR] && !wr_mask |=> irq && status[`ADCF_EVT_OVR])
        else $error("over-range event did not raise interrupt");

endmodule

// File: testbench/adcf_far_end.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// receiving logic at the output pins
// ----------------------------------------------------------------
module adcf_far_end
    import adcf_pkg::*;
(
    input  wire logic       pclk,
    input  wire adcf_word_t data_out,
    input  wire logic       over_range_flag,
    input  wire logic       data_oe_n,
    output adcf_word_t      bus_word,
    output logic            bus_over
);
    adcf_word_t held_word;
    logic       held_over;

    // last level seen while the pins were driven
    always_ff @(posedge pclk) begin
        if (!data_oe_n) begin
            held_word <= data_out;
            held_over <= over_range_flag;
        end
    end

    // released pins float, shown as the inverse of the last level
    assign bus_word = data_oe_n ? ~held_word : data_out;
    assign bus_over = data_oe_n ? ~held_over : over_range_flag;
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps

module testbench;
    import adcf_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    adcf_word_t  core_code, data_out, bus_word;
    logic        core_over, over_range_flag, data_valid, data_oe_n, irq, bus_over;
    int          miscompares, checks_done, n;
    logic [4:0]  cyc = 5'h00;
    adcf_word_t  in_code[32], out_word[32];
    logic        in_over[32], out_over[32], out_valid[32];

    adcf_top adcf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_code(core_code), .core_over(core_over), .data_out(data_out),
        .over_range_flag(over_range_flag), .data_valid(data_valid), .data_oe_n(data_oe_n), .irq(irq));
    adcf_far_end adcf_far_end_inst (.pclk(pclk), .data_out(data_out), .over_range_flag(over_range_flag),
        .data_oe_n(data_oe_n), .bus_word(bus_word), .bus_over(bus_over));

    // steady 25 MHz clock, equal high and low time
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ring of what crossed the pins at each edge
    always @(posedge pclk) begin
        cyc <= cyc + 5'h01;
        in_code[cyc] <= core_code;
        in_over[cyc] <= core_over;
        out_word[cyc] <= data_out;
        out_over[cyc] <= over_range_flag;
        out_valid[cyc] <= data_valid;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 8);
        if (pready !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        cmp(what, exp, rd);
    endtask

    // 32-sample stream with edge codes, then words judged at twenty edges
    task automatic stream(input logic twos);
        adcf_word_t c;
        logic [4:0] s;
        for (int i = 0; i < 32; i++) begin
            @(posedge pclk);
            core_code <= (i == 8) ? 14'h3fff : (i == 9) ? 14'h0000 : (i == 10) ? 14'h2000 : 14'(i * 16'h0123);
            core_over <= (i < 20) && (i % 3 == 0);
        end
        #1;
        for (int k = 1; k <= 20; k++) begin
            s = cyc - 5'(k + 11);
            c = twos ? {~in_code[s][13], in_code[s][12:0]} : in_code[s];
            cmp("word", 32'(c), 32'(out_word[5'(cyc - k)]));
            cmp("over", 32'(in_over[s]), 32'(out_over[5'(cyc - k)]));
            cmp("valid", 32'h1, 32'(out_valid[5'(cyc - k)]));
        end
        core_over <= 1'b0;
        $display("stream test done");
    endtask

    task automatic t_irq();
        rchk(8'h0c, 32'h0000_a33d, "last");
        rchk(8'h04, 32'h3, "status");
        cmp("irq off", 32'h0, 32'(irq));
        apb(1'b1, 8'h08, 32'h1);
        #1 cmp("irq on", 32'h1, 32'(irq));
        apb(1'b1, 8'h04, 32'h3);
        rchk(8'h04, 32'h0, "status");
        #1 cmp("irq clr", 32'h0, 32'(irq));
        apb(1'b1, 8'h08, 32'h3);
        $display("irq test done");
    endtask

    // power-down empties the pipe, full latency before words return
    task automatic t_pd();
        apb(1'b1, 8'h00, 32'h4);
        repeat (2) @(posedge pclk);
        #1 cmp("pd valid", 32'h0, 32'(data_valid));
        cmp("pd word", 32'h0, 32'(data_out));
        apb(1'b1, 8'h00, 32'h0);
        n = 0;
        while (data_valid !== 1'b1 && n < 40) begin
            @(posedge pclk);
            #1 n++;
        end
        cmp("resume", 32'd11, 32'(n));
        @(posedge pclk);
        #1 cmp("irq res", 32'h1, 32'(irq));
        rchk(8'h04, 32'h2, "status");
        apb(1'b1, 8'h04, 32'h2);
        $display("power-down test done");
    endtask

    // enable released once and restored, never toggled fast
    task automatic t_oe();
        #1 cmp("bus", 32'(data_out), 32'(bus_word));
        apb(1'b1, 8'h00, 32'h2);
        #1 cmp("oe off", 32'h1, 32'(data_oe_n));
        apb(1'b1, 8'h00, 32'h0);
        #1 cmp("oe on", 32'h0, 32'(data_oe_n));
        apb(1'b0, 8'h10, 32'h0);
        cmp("slverr", 32'h1, 32'(err));
        cmp("unmapped", 32'h0, rd);
        $display("enable test done");
    endtask

    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        core_code = 14'h0000;
        core_over = 1'b0;
        miscompares = 0;
        checks_done = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1 cmp("oe rst", 32'h0, 32'(data_oe_n));
        rchk(8'h00, 32'h0, "ctrl rst");
        rchk(8'h08, 32'h0, "mask rst");
        stream(1'b0);
        apb(1'b1, 8'h00, 32'h1);
        stream(1'b1);
        apb(1'b1, 8'h00, 32'h0);
        repeat (12) @(posedge pclk);
        t_irq();
        t_pd();
        t_oe();
        print_verdict();
    end
endmodule
